// ---- logic/event_status_consts.svh ----
// Constants and behaviour list for the event status reporting block
// Behaviour
// - Event flag sticks until flags query clears
// - Reset or clear-status command clears all flags not set in the same cycle
// - Power-up clears flags, then sets bit 7
// - Local-key user request sets bit 6
// - Command parse errors set bit 5
// - Execution range or conflict errors set bit 4
// - Internal device function error sets bit 3
// - Read without prior query sets bit 2
// - New command over unread output: bit 2, discard
// - Needing bus control sets bit 1
// - Operation complete sets bit 0 when idle
// - Controller enable mask selects summary sources
// - Summary is OR of flags AND mask
// - Summary drops once the condition ends
// - Power-up clears enable mask only if flag set
// - Enable mask written and read back by commands
// - Service request from status byte and request mask
`ifndef EVENT_STATUS_CONSTS_SVH
`define EVENT_STATUS_CONSTS_SVH
`define FLAG_W 8
`define BIT_OPC 0
`define BIT_REQ_CTRL 1
`define BIT_QUERY_ERR 2
`define BIT_DEV_ERR 3
`define BIT_EXEC_ERR 4
`define BIT_CMD_ERR 5
`define BIT_USER_REQ 6
`define BIT_POWER_ON 7
`define STB_MAV_BIT 4
`define STB_ESB_BIT 5
`define STB_RQS_BIT 6
`define FLAGS_RESET 8'h00
`define MASK_CLEAR 8'h00
`define BYTE_ZERO 8'h00
`endif

// ---- logic/event_status_pkg.sv ----
// Types shared by the event status reporting modules
package event_status_pkg;
    // One status byte
    typedef logic [7:0] byte_t;
    // Power-up sequencing
    typedef enum logic {pwr_boot, pwr_run} pwr_state_e;
    // Operation complete tracking
    typedef enum logic {opc_idle, opc_wait} opc_state_e;
endpackage : event_status_pkg

// ---- logic/status_if.sv ----
// Carrier between the reporting core and its flag and summary helpers
`timescale 1ns/100ps
interface status_if;
    import event_status_pkg::*;
    byte_t set_vec; // Event set strobes, one per flag
    byte_t rd_clr; // Flags handed out by a read, to clear
    logic clr_all; // Clear every flag not set in the same cycle
    byte_t flags; // Current event flags
    byte_t event_enable_mask; // Event enable mask
    byte_t request_enable_mask; // Request enable mask
    logic mav; // Output data waiting
    logic [3:0] ext_sum; // Summary bits of other registers
    byte_t stb; // Status byte
    logic srq; // Service request
    modport latch (input set_vec, rd_clr, clr_all, output flags);
    modport summ (input flags, event_enable_mask, request_enable_mask, mav, ext_sum, output stb, srq);
    modport core (output set_vec, rd_clr, clr_all, event_enable_mask, request_enable_mask, mav, ext_sum, input flags, stb, srq);
endinterface : status_if

// ---- logic/event_latch.sv ----
// Sticky event flag register with set-wins clearing
`timescale 1ns/100ps
`include "event_status_consts.svh"
module event_latch
    import event_status_pkg::*;
(
    input wire logic core_clk, // Device clock
    input wire logic resetn, // Async reset, active low
    status_if.latch st // Set, clear and flag state
);
    byte_t flags_ff; // Held event flags
    byte_t nxt_flags; // Next flag values

    // Per-bit next value; a set in the clearing cycle survives
    generate
        for (genvar i = 0; i < `FLAG_W; i++)
        begin : g_flag
            assign nxt_flags[i] = (flags_ff[i] & ~st.rd_clr[i] & ~st.clr_all) | st.set_vec[i];
        end
    endgenerate

    // Flag register; reset value is the power-up clear
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            flags_ff <= `FLAGS_RESET;
        else
            flags_ff <= nxt_flags;
    end

    assign st.flags = flags_ff;

    a_set_holds_flag: assert property (@(posedge core_clk) disable iff (!resetn)
        (st.set_vec != `BYTE_ZERO) |=> ((flags_ff & $past(st.set_vec)) == $past(st.set_vec)))
        else $error("Event set did not latch its flag");

    a_read_clears_returned: assert property (@(posedge core_clk) disable iff (!resetn)
        (st.rd_clr != `BYTE_ZERO) |=> ((flags_ff & $past(st.rd_clr) & ~$past(st.set_vec)) == `BYTE_ZERO))
        else $error("Read flags not cleared");
endmodule : event_latch

// ---- logic/summary_gen.sv ----
// Event summary bit, status byte and service request generation
`timescale 1ns/100ps
`include "event_status_consts.svh"
module summary_gen
    import event_status_pkg::*;
(
    input wire logic core_clk, // Device clock
    input wire logic resetn, // Async reset, active low
    status_if.summ st // Flags, masks and status outputs
);
    byte_t stb_ff; // Registered status byte
    logic srq_ff; // Registered service request
    byte_t nxt_stb; // Next status byte
    logic nxt_srq; // Next service request

    // Status byte assembly; recomputed every cycle so it falls by itself
    always_comb
    begin
        nxt_stb = `BYTE_ZERO;
        nxt_stb[3:0] = st.ext_sum;
        nxt_stb[`STB_MAV_BIT] = st.mav;
        nxt_stb[`STB_ESB_BIT] = |(st.flags & st.event_enable_mask);
        // request from enabled bits; RQS bit itself is not a source
        nxt_srq = |(nxt_stb & st.request_enable_mask);
        nxt_stb[`STB_RQS_BIT] = nxt_srq;
    end

    // Status registers
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            stb_ff <= `BYTE_ZERO;
            srq_ff <= 1'b0;
        end
        else
        begin
            stb_ff <= nxt_stb;
            srq_ff <= nxt_srq;
        end
    end

    assign st.stb = stb_ff;
    assign st.srq = srq_ff;

    a_summary_follows: assert property (@(posedge core_clk) disable iff (!resetn)
        ##1 (stb_ff[`STB_ESB_BIT] == (|($past(st.flags) & $past(st.event_enable_mask)))))
        else $error("Summary bit disagrees with flags and mask");

    a_request_cause: assert property (@(posedge core_clk) disable iff (!resetn)
        ((st.flags & st.event_enable_mask) != `BYTE_ZERO) && st.request_enable_mask[`STB_ESB_BIT] |=> srq_ff && stb_ff[`STB_RQS_BIT])
        else $error("Enabled summary did not raise service request");
endmodule : summary_gen

// ---- logic/event_status_reporting.sv ----
// Event status reporting core: command handling, event sources and masks
`timescale 1ns/100ps
`include "event_status_consts.svh"
module event_status_reporting
    import event_status_pkg::*;
(
    input wire logic core_clk, // Device clock, 100 MHz
    input wire logic resetn, // Power-on reset, active low
    input wire logic power_on_clear_flag, // Mask clear at power-up
    input wire logic user_request, // Local key pressed, pulse
    input wire logic parse_error, // Command parse error, pulse
    input wire logic exec_error, // Command execution error, pulse
    input wire logic device_fault, // Internal function error, pulse
    input wire logic ctrl_read_attempt, // Controller reads output, pulse
    input wire logic query_outstanding, // A query preceded the read
    input wire logic new_cmd, // New command arrives, pulse
    input wire logic need_control, // Device wants bus control, pulse
    input wire logic opc_cmd, // Operation complete request, pulse
    input wire logic cmd_busy, // Earlier commands still running
    input wire logic output_pending, // Output buffer holds data
    input wire logic [3:0] ext_summary, // Other summary bits, byte 3:0
    input wire logic flags_query, // Read and clear flags, pulse
    input wire logic ese_write, // Load event enable mask, pulse
    input wire logic ese_query, // Read event enable mask, pulse
    input wire logic sre_write, // Load request enable mask, pulse
    input wire logic sre_query, // Read request enable mask, pulse
    input wire logic stb_query, // Read status byte, pulse
    input wire logic [7:0] wr_value, // Value for mask loads
    input wire logic reset_cmd, // Standard reset command, pulse
    input wire logic clear_cmd, // Clear-status command, pulse
    output logic [7:0] rd_data, // Query answer
    output logic rd_valid, // Answer strobe, one cycle
    output logic [7:0] status_summary_byte, // Live status byte
    output logic service_request, // Service request line
    output logic outbuf_discard // Drop output buffer, pulse
);
    status_if st (); // Link to flag and summary helpers

    // Power-up and operation-complete state
    pwr_state_e pwr_ff;
    pwr_state_e nxt_pwr;
    opc_state_e opc_ff;
    opc_state_e nxt_opc;

    // Masks have no async reset: they must survive power-up when
    // the clear flag is 0, so the value is only defined once written or cleared at power-up
    byte_t ese_ff;
    byte_t nxt_ese;
    byte_t sre_ff;
    byte_t nxt_sre;

    // Answer and discard outputs
    byte_t rd_data_ff;
    byte_t nxt_rd_data;
    logic rd_valid_ff;
    logic nxt_rd_valid;
    logic discard_ff;
    logic nxt_discard;

    // Combinational event decode
    byte_t set_vec; // Flags set this cycle
    logic query_err; // Query error this cycle
    logic opc_done; // Operation complete reached

    // Sequencing of power-up and operation complete
    always_comb
    begin
        nxt_pwr = pwr_ff;
        nxt_opc = opc_ff;
        opc_done = 1'b0;
        unique case (pwr_ff)
            pwr_boot:
            begin
                // One cycle of power-up work, then normal running
                nxt_pwr = pwr_run;
            end
            pwr_run:
            begin
                nxt_pwr = pwr_run;
            end
        endcase
        unique case (opc_ff)
            opc_idle:
            begin
                if (opc_cmd && cmd_busy)
                    nxt_opc = opc_wait;
                else if (opc_cmd)
                    opc_done = 1'b1;
            end
            opc_wait:
            begin
                // Finishes as soon as the command queue drains
                if (!cmd_busy)
                begin
                    opc_done = 1'b1;
                    nxt_opc = opc_idle;
                end
            end
        endcase
        // Reset command abandons a pending completion
        if (reset_cmd)
            nxt_opc = opc_idle;
    end

    // State registers
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pwr_ff <= pwr_boot;
            opc_ff <= opc_idle;
        end
        else
        begin
            pwr_ff <= nxt_pwr;
            opc_ff <= nxt_opc;
        end
    end

    // Event sources onto their flag bits
    always_comb
    begin
        set_vec = `BYTE_ZERO;
        // read with no query before it
        query_err = ctrl_read_attempt && !query_outstanding;
        if (new_cmd && output_pending)
            query_err = 1'b1;
        set_vec[`BIT_POWER_ON] = (pwr_ff == pwr_boot);
        set_vec[`BIT_USER_REQ] = user_request;
        set_vec[`BIT_CMD_ERR] = parse_error;
        set_vec[`BIT_EXEC_ERR] = exec_error;
        set_vec[`BIT_DEV_ERR] = device_fault;
        set_vec[`BIT_QUERY_ERR] = query_err;
        set_vec[`BIT_REQ_CTRL] = need_control;
        set_vec[`BIT_OPC] = opc_done;
    end

    // Drive helpers
    assign st.set_vec = set_vec;
    // clear only what the query returns
    assign st.rd_clr = flags_query ? st.flags : `BYTE_ZERO;
    assign st.clr_all = reset_cmd || clear_cmd;
    assign st.event_enable_mask = ese_ff;
    assign st.request_enable_mask = sre_ff;
    assign st.mav = output_pending;
    assign st.ext_sum = ext_summary;

    // Mask next values
    always_comb
    begin
        nxt_ese = ese_ff;
        nxt_sre = sre_ff;
        if (pwr_ff == pwr_boot)
        begin
            // clear masks only with clear flag
            if (power_on_clear_flag)
            begin
                nxt_ese = `MASK_CLEAR;
                nxt_sre = `MASK_CLEAR;
            end
        end
        else
        begin
            if (ese_write)
                nxt_ese = wr_value;
            if (sre_write)
                nxt_sre = wr_value;
        end
    end

    // Mask registers, deliberately without reset
    always_ff @(posedge core_clk)
    begin
        ese_ff <= nxt_ese;
        sre_ff <= nxt_sre;
    end

    // Query answers; only one query is served per cycle
    always_comb
    begin
        nxt_rd_data = rd_data_ff;
        nxt_rd_valid = 1'b1;
        if (flags_query)
            nxt_rd_data = st.flags;
        else if (ese_query)
            nxt_rd_data = ese_ff;
        else if (sre_query)
            nxt_rd_data = sre_ff;
        // Status byte read leaves everything unchanged
        else if (stb_query)
            nxt_rd_data = st.stb;
        else
            nxt_rd_valid = 1'b0;
        nxt_discard = new_cmd && output_pending;
    end

    // Answer registers
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rd_data_ff <= `BYTE_ZERO;
            rd_valid_ff <= 1'b0;
            discard_ff <= 1'b0;
        end
        else
        begin
            rd_data_ff <= nxt_rd_data;
            rd_valid_ff <= nxt_rd_valid;
            discard_ff <= nxt_discard;
        end
    end

    // Sticky flags
    event_latch u_latch (
        .core_clk (core_clk),
        .resetn (resetn),
        .st (st.latch)
    );

    // Summary bit and service request
    summary_gen u_summary (
        .core_clk (core_clk),
        .resetn (resetn),
        .st (st.summ)
    );

    // Outputs straight from flip-flops
    assign rd_data = rd_data_ff;
    assign rd_valid = rd_valid_ff;
    assign outbuf_discard = discard_ff;
    assign status_summary_byte = st.stb;
    assign service_request = st.srq;

    a_power_on_bit: assert property (@(posedge core_clk) disable iff (!resetn)
        (pwr_ff == pwr_boot) |=> st.flags[`BIT_POWER_ON] && (pwr_ff == pwr_run))
        else $error("Power-on flag not set after power-up");

    a_query_answer: assert property (@(posedge core_clk) disable iff (!resetn)
        flags_query |=> rd_valid_ff && (rd_data_ff == $past(st.flags)))
        else $error("Flags query answer wrong");

    a_clear_all: assert property (@(posedge core_clk) disable iff (!resetn)
        (reset_cmd || clear_cmd) && (set_vec == `BYTE_ZERO) |=> (st.flags == `BYTE_ZERO))
        else $error("Flags not cleared by reset or clear-status");

    a_opc_waits: assert property (@(posedge core_clk) disable iff (!resetn)
        (opc_ff == opc_wait) && cmd_busy && !st.flags[`BIT_OPC] && !st.clr_all |=> !st.flags[`BIT_OPC])
        else $error("Operation complete set while busy");

    a_discard_query: assert property (@(posedge core_clk) disable iff (!resetn)
        new_cmd && output_pending |=> discard_ff && st.flags[`BIT_QUERY_ERR])
        else $error("Unread output not discarded with query error");

    a_ese_readback: assert property (@(posedge core_clk) disable iff (!resetn)
        ese_write && (pwr_ff == pwr_run) ##1 ese_query && !flags_query |=> (rd_data_ff == $past(wr_value, 2)))
        else $error("Enable mask read back differs");

    a_mask_psc: assert property (@(posedge core_clk) disable iff (!resetn)
        (pwr_ff == pwr_boot) && power_on_clear_flag |=> (ese_ff == `MASK_CLEAR) && (sre_ff == `MASK_CLEAR))
        else $error("Masks not cleared at power-up");

    // Each event source must land in its own flag on the next edge

    a_user_request_bit: assert property (@(posedge core_clk) disable iff (!resetn)
        user_request |=> st.flags[`BIT_USER_REQ])
        else $error("Local key request did not set its flag");

    a_parse_error_bit: assert property (@(posedge core_clk) disable iff (!resetn)
        parse_error |=> st.flags[`BIT_CMD_ERR])
        else $error("Parse error did not set its flag");

    a_exec_error_bit: assert property (@(posedge core_clk) disable iff (!resetn)
        exec_error |=> st.flags[`BIT_EXEC_ERR])
        else $error("Execution error did not set its flag");

    a_device_fault_bit: assert property (@(posedge core_clk) disable iff (!resetn)
        device_fault |=> st.flags[`BIT_DEV_ERR])
        else $error("Device fault did not set its flag");

    a_read_query_error: assert property (@(posedge core_clk) disable iff (!resetn)
        ctrl_read_attempt && !query_outstanding |=> st.flags[`BIT_QUERY_ERR])
        else $error("Read without query did not set query error");

    a_control_request_bit: assert property (@(posedge core_clk) disable iff (!resetn)
        need_control |=> st.flags[`BIT_REQ_CTRL])
        else $error("Bus control request did not set its flag");

    a_opc_immediate: assert property (@(posedge core_clk) disable iff (!resetn)
        opc_cmd && !cmd_busy && (opc_ff == opc_idle) |=> st.flags[`BIT_OPC])
        else $error("Operation complete missing with nothing pending");

    a_mask_kept: assert property (@(posedge core_clk) disable iff (!resetn)
        (pwr_ff == pwr_boot) && !power_on_clear_flag |=> (ese_ff == $past(ese_ff)) && (sre_ff == $past(sre_ff)))
        else $error("Masks changed at power-up without clear flag");

    a_discard_pulse: assert property (@(posedge core_clk) disable iff (!resetn)
        !(new_cmd && output_pending) |=> !discard_ff)
        else $error("Output discard without a new command over unread data");
endmodule : event_status_reporting

// ---- tb/bus_host.sv ----
// Bus controller model: command strobes, mask loads and queries
`timescale 1ns/100ps
module bus_host
    import event_status_pkg::*;
(
    input wire logic core_clk, // Device clock
    input wire logic [7:0] rd_data, // Query answer
    input wire logic rd_valid, // Answer strobe
    output logic [9:0] cmd_vec, // One strobe per command kind
    output logic [7:0] wr_value, // Mask value lines
    output logic query_outstanding // A query preceded the read
);
    // Quiet bus at time zero
    initial
    begin
        cmd_vec = 10'h000;
        wr_value = 8'h00;
        query_outstanding = 1'b1;
    end

    // One-cycle strobe; callers enter right after a falling edge
    task pulse(input int which);
        cmd_vec[which] = 1'b1;
        @(negedge core_clk);
        cmd_vec[which] = 1'b0;
    endtask : pulse

    task write(input int which, input byte_t value);
        wr_value = value;
        pulse(which);
        // Released lines must not keep showing the value
        wr_value = ~value;
        // One quiet cycle keeps back-to-back loads from touching the lines twice
        @(negedge core_clk);
    endtask : write

    // Query, then take the answer while its strobe stands
    task query(input int which, output byte_t data);
        data = 8'hxx;
        pulse(which);
        // Answer strobe rose on the edge that took the query and stands one cycle
        if (rd_valid === 1'b1)
            data = rd_data;
        repeat (2) @(negedge core_clk);
    endtask : query

    // mask load with its read-back on the very next edge
    task write_query(input int which, input byte_t value, output byte_t data);
        wr_value = value;
        cmd_vec[which] = 1'b1;
        @(negedge core_clk);
        wr_value = ~value;
        cmd_vec[which] = 1'b0;
        // The matching query strobe sits one above the load strobe
        query(which + 1, data);
    endtask : write_query

    // controller reads output; asked tells whether a query came first
    task read_out(input logic asked);
        query_outstanding = asked;
        pulse(9);
        query_outstanding = 1'b1;
    endtask : read_out
endmodule : bus_host

// ---- tb/event_status_reporting_test.sv ----
// Self-checking bench for the event status reporting block
`timescale 1ns/100ps
module event_status_reporting_test
    import event_status_pkg::*;
;
    logic core_clk = 1'b0; // Device clock
    logic resetn = 1'b0; // Power-on reset, active low
    logic power_on_clear_flag = 1'b1; // Mask clear at power-up
    logic [5:0] ev = 6'h00; // User, parse, exec, device, control, opc
    logic cmd_busy = 1'b0; // Earlier commands running
    logic output_pending = 1'b0; // Output buffer holds data
    logic [3:0] ext_summary = 4'h0; // Other summary bits
    logic [9:0] cmd_vec; // Controller strobes
    logic [7:0] wr_value; // Mask value
    logic query_outstanding; // Read qualifier
    logic [7:0] rd_data; // Query answer
    logic rd_valid; // Answer strobe
    logic [7:0] status_summary_byte; // Live status byte
    logic service_request; // Service request line
    logic outbuf_discard; // Output drop pulse
    int fails = 0; // Mismatches seen
    int cmp_count = 0; // Comparisons made
    byte_t got; // Last answer

    // 100 MHz clock
    always #5 core_clk = ~core_clk;

    // Strobe map: 0 flags?, 1 ese, 2 ese?, 3 sre, 4 sre?, 5 stb?, 6 rst, 7 cls, 8 cmd, 9 read
    bus_host host (.core_clk(core_clk), .rd_data(rd_data), .rd_valid(rd_valid), .cmd_vec(cmd_vec),
        .wr_value(wr_value), .query_outstanding(query_outstanding));

    event_status_reporting uut (.core_clk(core_clk), .resetn(resetn),
        .power_on_clear_flag(power_on_clear_flag), .user_request(ev[0]), .parse_error(ev[1]),
        .exec_error(ev[2]), .device_fault(ev[3]), .ctrl_read_attempt(cmd_vec[9]),
        .query_outstanding(query_outstanding), .new_cmd(cmd_vec[8]), .need_control(ev[4]),
        .opc_cmd(ev[5]), .cmd_busy(cmd_busy), .output_pending(output_pending), .ext_summary(ext_summary),
        .flags_query(cmd_vec[0]), .ese_write(cmd_vec[1]), .ese_query(cmd_vec[2]), .sre_write(cmd_vec[3]),
        .sre_query(cmd_vec[4]), .stb_query(cmd_vec[5]), .wr_value(wr_value), .reset_cmd(cmd_vec[6]),
        .clear_cmd(cmd_vec[7]), .rd_data(rd_data), .rd_valid(rd_valid),
        .status_summary_byte(status_summary_byte), .service_request(service_request),
        .outbuf_discard(outbuf_discard));

    // Compare one value and count it
    task check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task conclude;
        if (fails == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude

    task cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask : cyc

    // Query and judge the answer
    task ask(input int which, input byte_t exp);
        host.query(which, got);
        check(got, exp);
        // Answer strobe must have fallen again
        check({7'h00, rd_valid}, 8'h00);
    endtask : ask

    // Event pulse, then one cycle for the flag to land
    task fire(input int i);
        ev[i] = 1'b1;
        cyc(1);
        ev[i] = 1'b0;
        cyc(1);
    endtask : fire

    // Hold reset 8 cycles, power-up cycle passes before requests
    task power_up(input logic clr);
        resetn = 1'b0;
        power_on_clear_flag = clr;
        cyc(8);
        resetn = 1'b1;
        cyc(3);
    endtask : power_up

    task t_sources;
        byte_t bits[6] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h02, 8'h01};
        for (int i = 0; i < 6; i++)
        begin
            fire(i);
            fire(i);
            ask(0, bits[i]);
            ask(0, 8'h00);
        end
        // Read without a query, then a legal read
        host.read_out(1'b0);
        cyc(1);
        ask(0, 8'h04);
        host.read_out(1'b1);
        cyc(1);
        ask(0, 8'h00);
    endtask : t_sources

    task t_opc_clear;
        cmd_busy = 1'b1;
        fire(5);
        cyc(4);
        ask(0, 8'h00);
        cmd_busy = 1'b0;
        cyc(3);
        ask(0, 8'h01);
        // Both clearing commands
        for (int k = 6; k < 8; k++)
        begin
            fire(1);
            fire(3);
            host.pulse(k);
            cyc(1);
            ask(0, 8'h00);
        end
    endtask : t_opc_clear

    task t_discard;
        output_pending = 1'b1;
        host.pulse(8);
        // Discard stands one cycle, from the edge that took the command
        check({7'h00, outbuf_discard}, 8'h01);
        cyc(1);
        check({7'h00, outbuf_discard}, 8'h00);
        ask(0, 8'h04);
        output_pending = 1'b0;
        host.pulse(8);
        check({7'h00, outbuf_discard}, 8'h00);
        cyc(1);
        ask(0, 8'h00);
    endtask : t_discard

    task t_summary;
        ext_summary = 4'ha;
        output_pending = 1'b1;
        host.write(1, 8'h10);
        host.write(3, 8'h20);
        fire(1);
        cyc(2);
        check(status_summary_byte, 8'h1a);
        check({7'h00, service_request}, 8'h00);
        host.write(1, 8'h30);
        cyc(2);
        check(status_summary_byte, 8'h7a);
        check({7'h00, service_request}, 8'h01);
        ask(5, 8'h7a);
        ask(2, 8'h30);
        ask(4, 8'h20);
        host.write(1, 8'h00);
        cyc(2);
        check(status_summary_byte, 8'h1a);
        host.write(1, 8'h20);
        ask(0, 8'h20);
        cyc(2);
        check(status_summary_byte, 8'h1a);
        check({7'h00, service_request}, 8'h00);
        output_pending = 1'b0;
        ext_summary = 4'h0;
    endtask : t_summary

    task t_same_cycle;
        fire(0);
        // Event lands on the very edge that takes the read
        fork
            host.query(0, got);
            fire(1);
        join
        check(got, 8'h40);
        ask(0, 8'h20);
    endtask : t_same_cycle

    task t_repower;
        host.write(1, 8'h5a);
        host.write(3, 8'h24);
        power_up(1'b0);
        ask(2, 8'h5a);
        ask(4, 8'h24);
        ask(0, 8'h80);
        // Load and read back on consecutive edges
        host.write_query(1, 8'ha5, got);
        check(got, 8'ha5);
    endtask : t_repower

    // Main sequence
    initial
    begin
        power_up(1'b1);
        ask(0, 8'h80);
        ask(0, 8'h00);
        ask(2, 8'h00);
        ask(4, 8'h00);
        t_sources;
        t_opc_clear;
        t_discard;
        t_summary;
        t_same_cycle;
        t_repower;
        conclude;
    end

    // Watchdog: the run needs about 200 cycles, allow a hundred times that
    initial
    begin
        #200000;
        fails++;
        conclude;
    end
endmodule : event_status_reporting_test
